// ==== verilog/tra_pkg.sv ====
/*
 * constants, carriers and register field positions of the temperature result formatter
 * and alert block.
 * assumes a single 250 mhz system clock, an apb master with 32-bit data and
 * a conversion front end that presents one local/remote pair per rising link edge.
 */
// Notes on behaviour
// - cfg2 d2:d1 select filter; 00 off, 11 on
// - filter off: 11-bit remote words, 1/8 degree
// - filter on: 13-bit remote words, 1/32 degree
// - signed words: degrees in upper byte, two's complement
// - unsigned remote spans 0 to 255.875 degrees, 255.96875 with filter on
// - filtered unsigned lsb weight is 0008h
// - local word 11-bit signed, 1/8 degree, left-justified
// - local readings clamp at 127.875, never wrap
// - only temperature registers return reading data
// - critical output low when any result over limit
// - critical released when all below limit minus hysteresis
// - remote over critical limit sets status flag
// - local over shared limit sets status flag
// - outputs and flags update once per pair
// - overtemp output asserted when any result over limit
// - remote over overtemp limit sets status flag
// - diode fault forces -128 / 255.875, sets d2
// - register pointer resets to local temperature
// - pointer holds until written again
// - filter adds no steady offset
// - comparisons use filtered remote when filter on
// - config1 mask bits gate each channel onto outputs
package tra_pkg;

   // ****************************************************
   // register indices (byte address is four times these)
   // ****************************************************
   localparam logic [7:0] IDX_LOCAL_MSB = 8'h00;
   localparam logic [7:0] IDX_LOCAL_LSB = 8'h30;
   localparam logic [7:0] IDX_REM_SIGNED_MSB = 8'h01;
   localparam logic [7:0] IDX_REM_SIGNED_LSB = 8'h10;
   localparam logic [7:0] IDX_REM_UNSIGNED_MSB = 8'h31;
   localparam logic [7:0] IDX_REM_UNSIGNED_LSB = 8'h32;
   localparam logic [7:0] IDX_STATUS1 = 8'h02;
   localparam logic [7:0] IDX_CFG1_A = 8'h03;
   localparam logic [7:0] IDX_CFG1_B = 8'h09;
   localparam logic [7:0] IDX_CFG2 = 8'hbf;
   localparam logic [7:0] IDX_REM_CRIT_LIMIT = 8'h19;
   localparam logic [7:0] IDX_REM_OVERTEMP_LIMIT = 8'h07;
   localparam logic [7:0] IDX_LOCAL_LIMIT = 8'h20;
   localparam logic [7:0] IDX_HYSTERESIS = 8'h21;
   localparam logic [7:0] IDX_POINTER = 8'h80;
   localparam logic [7:0] IDX_DATA = 8'h81;

   // ****************************************************
   // field positions
   // ****************************************************
   localparam int CFG2_FILTER_SEL_HI = 2;
   localparam int CFG2_FILTER_SEL_LO = 1;
   localparam int CFG2_PIN_ADDR_MODE = 0;
   localparam int CFG2_FAULT_MASK_CRIT = 3;
   localparam int CFG2_FAULT_MASK_OVERTEMP = 4;
   localparam int CFG1_LOCAL_OVERTEMP_MASK = 0;
   localparam int CFG1_LOCAL_CRIT_MASK = 1;
   localparam int CFG1_REM_OVERTEMP_MASK = 3;
   localparam int CFG1_REM_CRIT_MASK = 4;
   localparam int ST_LOCAL_LIMIT_FLAG = 6;
   localparam int ST_ADDR_SELECT = 5;
   localparam int ST_REMOTE_CRITICAL_FLAG = 4;
   localparam int ST_REMOTE_OVERTEMP_FLAG = 3;
   localparam int ST_DIODE_FAULT = 2;
   localparam int ST_CRIT_PIN = 1;
   localparam int ST_OVERTEMP_PIN = 0;

   // ****************************************************
   // reset values and codes
   // ****************************************************
   localparam logic [7:0] CFG1_RST = 8'h00;
   localparam logic [7:0] CFG2_RST = 8'h1f;
   localparam logic [7:0] REM_CRIT_LIMIT_RST = 8'h6e;
   localparam logic [7:0] REM_OVERTEMP_LIMIT_RST = 8'h55;
   localparam logic [7:0] LOCAL_LIMIT_RST = 8'h55;
   localparam logic [7:0] HYSTERESIS_RST = 8'h0a;
   localparam logic [7:0] POINTER_RST = 8'h00;
   localparam logic [7:0] CFG1_WMASK = 8'h5b;
   localparam logic [1:0] FILTER_ON = 2'b11;
   localparam logic [15:0] SIGNED_FAULT_CODE = 16'h8000;
   localparam logic [15:0] UNSIGNED_FAULT_CODE = 16'hffe0;
   localparam int FILT_FRAC = 4;
   localparam int FILT_SHIFT = 2;

   // ****************************************************
   // carriers
   // ****************************************************
   typedef struct packed {
      logic [11:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
   } tra_apb_req_type;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } tra_apb_rsp_type;

   // local in 1/8 degree, remote in 1/32 degree, both two's complement
   typedef struct packed {
      logic [11:0] localRaw;
      logic [13:0] remoteRaw;
      logic diodeFault;
   } tra_conv_type;

endpackage

// ==== verilog/tra_result_alerts.sv ====
/*
 * result formatting, remote filter, limit compare and alert pins of the
 * temperature sensor, with its registers behind an apb slave.
 * assumes the front end changes its data on the falling edge of the
 * conversion clock and holds it across the rising edge that marks a pair.
 */
`timescale 1ns/1ns
module tra_result_alerts (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // register bus
   input wire tra_pkg::tra_apb_req_type apbReq,
   output tra_pkg::tra_apb_rsp_type apbRsp,
   // conversion link, foreign domain
   input wire logic convClkIn,
   input wire tra_pkg::tra_conv_type convIn,
   // critical alert pin, open drain
   input wire logic criticalAlertIn,
   output logic criticalAlertOut,
   output logic criticalAlertOeN,
   // shared overtemp / address pin, open drain
   input wire logic addrSelectIn,
   output logic overtempAlertOut,
   output logic overtempAlertOeN
);
   import tra_pkg::*;

   // ****************************************************
   // state
   // ****************************************************
   typedef struct packed {
      logic clkS1;                  // link clock synchroniser
      logic clkS2;
      logic clkS3;                  // edge detect history
      tra_conv_type convS1;         // data synchroniser
      tra_conv_type convS2;
      logic critPinS1;              // pin readback synchronisers
      logic critPinS2;
      logic addrS1;
      logic addrS2;
      logic [15:0] localWord;       // formatted results
      logic [15:0] remSigned;
      logic [15:0] remUnsigned;
      logic [17:0] filtAcc;         // filter with four guard bits
      logic filtPrimed;
      logic [7:0] cfg1;
      logic [7:0] cfg2;
      logic [7:0] remCriticalLimit;
      logic [7:0] remOvertempLimit;
      logic [7:0] localLimit;
      logic [7:0] hyst;
      logic [7:0] pointer;
      logic [7:0] status;
      logic critActive;
      logic overtempActive;
      logic critPinOut;
      logic critPinOeN;
      logic overtempPinOut;
      logic overtempPinOeN;
      tra_apb_rsp_type rsp;
   } tra_state_type;

   tra_state_type st;       // registered state
   tra_state_type next_st;  // next state

   // ****************************************************
   // helpers
   // ****************************************************
   // release threshold; a hysteresis above the limit pins it at zero
   function automatic logic [15:0] relThr(input logic [7:0] lim, input logic [7:0] h);
      relThr = (lim >= h) ? {8'(lim - h), 8'h00} : 16'h0000;
   endfunction

   // register byte seen by a read at index i
   function automatic logic [7:0] readByte(input logic [7:0] i, input tra_state_type s);
      case (i)
         IDX_LOCAL_MSB: readByte = s.localWord[15:8];
         IDX_LOCAL_LSB: readByte = s.localWord[7:0];
         IDX_REM_SIGNED_MSB: readByte = s.remSigned[15:8];
         IDX_REM_SIGNED_LSB: readByte = s.remSigned[7:0];
         IDX_REM_UNSIGNED_MSB: readByte = s.remUnsigned[15:8];
         IDX_REM_UNSIGNED_LSB: readByte = s.remUnsigned[7:0];
         IDX_STATUS1: readByte = s.status;
         IDX_CFG1_A, IDX_CFG1_B: readByte = s.cfg1;
         IDX_CFG2: readByte = s.cfg2;
         IDX_REM_CRIT_LIMIT: readByte = s.remCriticalLimit;
         IDX_REM_OVERTEMP_LIMIT: readByte = s.remOvertempLimit;
         IDX_LOCAL_LIMIT: readByte = s.localLimit;
         IDX_HYSTERESIS: readByte = s.hyst;
         IDX_POINTER: readByte = s.pointer;
         default: readByte = 8'h00;   // unmapped reads as zero
      endcase
   endfunction

   // indices that answer without error
   function automatic logic isMapped(input logic [7:0] i);
      case (i)
         IDX_LOCAL_MSB, IDX_LOCAL_LSB, IDX_REM_SIGNED_MSB, IDX_REM_SIGNED_LSB,
         IDX_REM_UNSIGNED_MSB, IDX_REM_UNSIGNED_LSB, IDX_STATUS1, IDX_CFG1_A,
         IDX_CFG1_B, IDX_CFG2, IDX_REM_CRIT_LIMIT, IDX_REM_OVERTEMP_LIMIT,
         IDX_LOCAL_LIMIT, IDX_HYSTERESIS, IDX_POINTER, IDX_DATA: isMapped = 1'b1;
         default: isMapped = 1'b0;
      endcase
   endfunction

   // ****************************************************
   // link edge and remote filter
   // ****************************************************
   logic pairEdge;                  // one completed local/remote pair
   logic filterOn;
   logic signed [13:0] remRaw;
   logic signed [17:0] filtTarget;
   logic signed [18:0] filtDiff;
   logic signed [18:0] filtStep;
   logic signed [18:0] filtRound;   // bias that rounds a rising step up
   logic [17:0] filtNew;
   logic signed [13:0] remNew;
   logic signed [11:0] localRaw;
   logic [12:0] remSig13;
   logic [12:0] remUns13;
   logic [10:0] local11;
   logic [15:0] remSigWord;
   logic [15:0] remUnsWord;
   logic [15:0] localWordNew;
   logic fault;

   // edge found from the second and third flops only
   assign pairEdge = st.clkS2 & ~st.clkS3;
   assign filterOn = ({st.cfg2[CFG2_FILTER_SEL_HI], st.cfg2[CFG2_FILTER_SEL_LO]}
                      == FILTER_ON);
   assign remRaw = $signed(st.convS2.remoteRaw);
   assign localRaw = $signed(st.convS2.localRaw);
   assign fault = st.convS2.diodeFault;
   assign filtTarget = {remRaw, 4'h0};
   assign filtDiff = {filtTarget[17], filtTarget} - {st.filtAcc[17], st.filtAcc};
   // a rising input rounds its step up and a falling one floors it, so the
   // accumulator lands exactly on a steady input and leaves no offset
   assign filtRound = filtDiff[18] ? 19'sd0 : 19'((1 << FILT_SHIFT) - 1);
   assign filtStep = (filtDiff + filtRound) >>> FILT_SHIFT;
   // reloaded while off or faulted, so turning it on starts from the raw value
   assign filtNew = (!filterOn || !st.filtPrimed || fault) ? filtTarget :
                    18'(st.filtAcc + filtStep[17:0]);
   assign remNew = filterOn ? $signed(filtNew[17:FILT_FRAC]) : remRaw;

   // ****************************************************
   // formatting
   // ****************************************************
   always_comb begin
      // signed remote: 12 bits plus sign, clamped to its range
      if (remNew > 14'sd4095) begin
         remSig13 = 13'h0fff;
      end else if (remNew < -14'sd4096) begin
         remSig13 = 13'h1000;
      end else begin
         remSig13 = remNew[12:0];
      end
      // unsigned remote: 0 to 255.96875
      if (remNew < 14'sd0) begin
         remUns13 = 13'h0000;
      end else if (remNew > 14'sd8191) begin
         remUns13 = 13'h1fff;
      end else begin
         remUns13 = remNew[12:0];
      end
      // filter off drops the two finest bits, unused bits stay zero
      if (!filterOn) begin
         remSig13[1:0] = 2'b00;
         remUns13[1:0] = 2'b00;
      end
      remSigWord = {remSig13, 3'b000};
      remUnsWord = {remUns13, 3'b000};
      if (fault) begin
         remSigWord = SIGNED_FAULT_CODE;
         remUnsWord = UNSIGNED_FAULT_CODE;
      end
      // local clamps at 127.875 rather than wrapping
      if (localRaw > 12'sd1023) begin
         local11 = 11'h3ff;
      end else if (localRaw < -12'sd1024) begin
         local11 = 11'h400;
      end else begin
         local11 = localRaw[10:0];
      end
      localWordNew = {local11, 5'b00000};
   end

   // ****************************************************
   // limit compare
   // ****************************************************
   logic remOverCrit;
   logic remOverOt;
   logic remBelowCrit;
   logic remBelowOt;
   logic localOver;
   logic localBelow;
   logic remCritGate;
   logic remOtGate;
   logic critSet;
   logic critClear;
   logic otSet;
   logic otClear;

   // remote compares on the unsigned word so limits reach 255 degrees
   assign remOverCrit = remUnsWord > {st.remCriticalLimit, 8'h00};
   assign remOverOt = remUnsWord > {st.remOvertempLimit, 8'h00};
   assign remBelowCrit = remUnsWord < relThr(st.remCriticalLimit, st.hyst);
   assign remBelowOt = remUnsWord < relThr(st.remOvertempLimit, st.hyst);
   // local limit is seven bits; negative readings are always below it
   assign localOver = !localWordNew[15] &&
                      (localWordNew > {1'b0, st.localLimit[6:0], 8'h00});
   assign localBelow = localWordNew[15] ||
                       (localWordNew < relThr({1'b0, st.localLimit[6:0]}, st.hyst));
   // a channel may drive a pin only when unmasked; a masked fault is ignored
   assign remCritGate = !st.cfg1[CFG1_REM_CRIT_MASK] &&
                        !(fault && st.cfg2[CFG2_FAULT_MASK_CRIT]);
   assign remOtGate = !st.cfg1[CFG1_REM_OVERTEMP_MASK] &&
                      !(fault && st.cfg2[CFG2_FAULT_MASK_OVERTEMP]);
   assign critSet = (remOverCrit && remCritGate) ||
                    (localOver && !st.cfg1[CFG1_LOCAL_CRIT_MASK]);
   assign critClear = (remBelowCrit || !remCritGate) &&
                      (localBelow || st.cfg1[CFG1_LOCAL_CRIT_MASK]);
   assign otSet = (remOverOt && remOtGate) ||
                  (localOver && !st.cfg1[CFG1_LOCAL_OVERTEMP_MASK]);
   assign otClear = (remBelowOt || !remOtGate) &&
                    (localBelow || st.cfg1[CFG1_LOCAL_OVERTEMP_MASK]);

   // ****************************************************
   // bus decode
   // ****************************************************
   logic apbSetup;
   logic apbWrite;
   logic [7:0] reqIdx;
   logic reqOk;
   logic [7:0] wrIdx;
   logic [7:0] wrData;

   assign apbSetup = apbReq.psel && !apbReq.penable;
   // writes land only on the edge that completes the access
   assign apbWrite = apbReq.psel && apbReq.penable && st.rsp.pready &&
                     apbReq.pwrite && !st.rsp.pslverr;
   assign reqIdx = apbReq.paddr[9:2];
   assign reqOk = (apbReq.paddr[1:0] == 2'b00) && (apbReq.paddr[11:10] == 2'b00) &&
                  isMapped(reqIdx);
   // the data window writes wherever the pointer stands, other than the pointer register itself
   assign wrIdx = (reqIdx == IDX_DATA) ? st.pointer : reqIdx;
   assign wrData = apbReq.pwdata[7:0];

   // ****************************************************
   // next state
   // ****************************************************
   always_comb begin
      next_st = st;
      // two flops on everything from the link and the pins
      next_st.clkS1 = convClkIn;
      next_st.clkS2 = st.clkS1;
      next_st.clkS3 = st.clkS2;
      next_st.convS1 = convIn;
      next_st.convS2 = st.convS1;
      next_st.critPinS1 = criticalAlertIn;
      next_st.critPinS2 = st.critPinS1;
      next_st.addrS1 = addrSelectIn;
      next_st.addrS2 = st.addrS1;
      // results, flags and alerts move only on a completed pair
      if (pairEdge) begin
         next_st.filtAcc = filtNew;
         next_st.filtPrimed = 1'b1;
         next_st.localWord = localWordNew;
         next_st.remSigned = remSigWord;
         next_st.remUnsigned = remUnsWord;
         next_st.status[ST_REMOTE_CRITICAL_FLAG] = remOverCrit;
         next_st.status[ST_REMOTE_OVERTEMP_FLAG] = remOverOt;
         next_st.status[ST_LOCAL_LIMIT_FLAG] = localOver;
         next_st.status[ST_DIODE_FAULT] = fault;
         if (critSet) begin
            next_st.critActive = 1'b1;
         end else if (critClear) begin
            next_st.critActive = 1'b0;
         end
         if (otSet) begin
            next_st.overtempActive = 1'b1;
         end else if (otClear) begin
            next_st.overtempActive = 1'b0;
         end
      end
      // live pin readback in the status byte, except the overtemp pin bit, which copies its own enable
      next_st.status[ST_CRIT_PIN] = st.critPinS2;
      next_st.status[ST_OVERTEMP_PIN] = st.overtempPinOeN;
      next_st.status[ST_ADDR_SELECT] = st.addrS2;
      // enables low means pulling the pin low
      next_st.critPinOeN = !st.critActive;
      next_st.overtempPinOeN = !(st.overtempActive &&
                                 !st.cfg2[CFG2_PIN_ADDR_MODE]);
      // one wait-free answer: pready rises for the access phase
      next_st.rsp.pready = apbSetup;
      next_st.rsp.pslverr = apbSetup && !reqOk;
      if (apbSetup) begin
         // the window reads the pointed register; readings come only from theirs
         next_st.rsp.prdata = {24'h000000,
            readByte((reqIdx == IDX_DATA) ? st.pointer : reqIdx, st)};
      end
      if (apbWrite) begin
         if (reqIdx == IDX_POINTER) begin
            next_st.pointer = wrData;
         end
         case (wrIdx)
            IDX_CFG1_A, IDX_CFG1_B: next_st.cfg1 = wrData & CFG1_WMASK;
            IDX_CFG2: next_st.cfg2 = {3'b000, wrData[4:0]};
            IDX_REM_CRIT_LIMIT: next_st.remCriticalLimit = wrData;
            IDX_REM_OVERTEMP_LIMIT: next_st.remOvertempLimit = wrData;
            IDX_LOCAL_LIMIT: next_st.localLimit = {1'b0, wrData[6:0]};
            IDX_HYSTERESIS: next_st.hyst = wrData;
            default: ;   // read-only targets ignore writes
         endcase
      end
   end

   // ****************************************************
   // state register
   // ****************************************************
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
         st.cfg1 <= CFG1_RST;
         st.cfg2 <= CFG2_RST;
         st.remCriticalLimit <= REM_CRIT_LIMIT_RST;
         st.remOvertempLimit <= REM_OVERTEMP_LIMIT_RST;
         st.localLimit <= LOCAL_LIMIT_RST;
         st.hyst <= HYSTERESIS_RST;
         st.pointer <= POINTER_RST;
         st.critPinOeN <= 1'b1;
         st.overtempPinOeN <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from flops
   assign apbRsp = st.rsp;
   assign criticalAlertOut = st.critPinOut;
   assign criticalAlertOeN = st.critPinOeN;
   assign overtempAlertOut = st.overtempPinOut;
   assign overtempAlertOeN = st.overtempPinOeN;

   // ****************************************************
   // assertions
   // ****************************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   a_filter_off_bits: assert property (pairEdge && !filterOn |=>
      st.remSigned[4:0] == 5'h00 && st.remUnsigned[4:0] == 5'h00)
      else $error("unused remote bits set with filter off");
   a_filter_on_bits: assert property (st.remSigned[2:0] == 3'h0 &&
      st.remUnsigned[2:0] == 3'h0)
      else $error("remote word below lsb not zero");
   a_local_clamp: assert property (pairEdge && localRaw > 12'sd1023 |=>
      st.localWord == 16'h7fe0)
      else $error("local reading not clamped");
   a_fault_codes: assert property (pairEdge && fault |=>
      st.remSigned == 16'h8000 && st.remUnsigned == 16'hffe0 && st.status[2])
      else $error("diode fault codes wrong");
   a_pointer_hold: assert property (!(apbWrite && reqIdx == IDX_POINTER) |=>
      $stable(st.pointer))
      else $error("pointer moved without a write");
   a_crit_timing: assert property (!pairEdge ##1 !pairEdge |=>
      $stable(st.critPinOeN))
      else $error("critical pin changed between pairs");
   a_crit_assert: assert property (pairEdge && critSet |=> ##1
      !criticalAlertOeN)
      else $error("critical pin not driven low");
   a_crit_release: assert property (pairEdge && !critSet && critClear |=> ##1
      criticalAlertOeN)
      else $error("critical pin not released");
   a_addr_mode: assert property (st.cfg2[CFG2_PIN_ADDR_MODE] |=>
      overtempAlertOeN)
      else $error("shared pin driven in address mode");
   a_overtemp_flag: assert property (pairEdge && remOverOt |=>
      st.status[ST_REMOTE_OVERTEMP_FLAG] ##1 st.status[ST_REMOTE_OVERTEMP_FLAG] || pairEdge)
      else $error("remote overtemp flag not set");

endmodule // tra_result_alerts

// ==== verification/tra_front_end.sv ====
/*
 * conversion front end model: one local/remote pair per link clock rise.
 * assumes the bench gates it with run and presets the next pair's values.
 */
`timescale 1ns/1ns
module tra_front_end (
   // control from the bench
   input wire logic run,
   input wire tra_pkg::tra_conv_type nextConv,
   // link towards the block
   output logic convClkIn,
   output tra_pkg::tra_conv_type convIn
);
   import tra_pkg::*;
   // ****************************************************
   // link clock, 64 ns period, still while run is low
   // ****************************************************
   initial begin
      convClkIn = 1'b0;
      convIn = '0;
      forever begin
         #32;
         // data moves on the fall so it is steady across the rise
         if (convClkIn) begin
            convClkIn = 1'b0;
            convIn = nextConv;
         end else if (run) begin
            convClkIn = 1'b1;
         end
      end
   end
endmodule // tra_front_end

// ==== verification/testbench.sv ====
/*
 * self-checking bench: apb register access, result formats and alert pins.
 * assumes a pulled-up wire on both open-drain pins and the front end model.
 */
`timescale 1ns/1ns
module testbench;
   import tra_pkg::*;
   // one case: settings, link input and expected outcome
   typedef struct packed {
      logic [7:0] cfg1, cfg2;
      logic [11:0] local_limit_flag;
      logic [13:0] rem;
      logic flt;
      logic [15:0] eLoc, eSgn, eUns;
      logic [7:0] eSt;
      logic eCrit, eOs;
   } tra_row_type;
   logic sys_clk, rst_n, run, criticalAlertIn, criticalAlertOut, criticalAlertOeN;
   logic addrSelectIn, overtempAlertOut, overtempAlertOeN, convClkIn;
   tra_apb_req_type apbReq;
   tra_apb_rsp_type apbRsp;
   tra_conv_type convIn, nextConv;
   int fail_count, n_checks;
   logic [31:0] rd;
   logic [15:0] w;
   tra_row_type r;
   tra_row_type rows [14] = '{
      '{8'h00, 8'h18, 12'h008, 14'h0020, 1'b0, 16'h0100, 16'h0100, 16'h0100, 8'h00, 1'b1, 1'b1},
      '{8'h00, 8'h18, 12'hfff, 14'h0021, 1'b0, 16'hffe0, 16'h0100, 16'h0100, 8'h00, 1'b1, 1'b1},
      '{8'h00, 8'h1e, 12'hfff, 14'h0021, 1'b0, 16'hffe0, 16'h0108, 16'h0108, 8'h00, 1'b1, 1'b1},
      '{8'h00, 8'h1e, 12'hfff, 14'h0025, 1'b0, 16'hffe0, 16'h0128, 16'h0128, 8'h00, 1'b1, 1'b1},
      '{8'h00, 8'h1e, 12'h400, 14'h0021, 1'b0, 16'h7fe0, 16'h0108, 16'h0108, 8'h40, 1'b0, 1'b0},
      '{8'h00, 8'h18, 12'h280, 14'h0021, 1'b0, 16'h5000, 16'h0100, 16'h0100, 8'h00, 1'b0, 1'b0},
      '{8'h00, 8'h18, 12'h230, 14'h0021, 1'b0, 16'h4600, 16'h0100, 16'h0100, 8'h00, 1'b1, 1'b1},
      '{8'h00, 8'h18, 12'h230, 14'h0f00, 1'b0, 16'h4600, 16'h7800, 16'h7800, 8'h18, 1'b0, 1'b0},
      '{8'h00, 8'h18, 12'h230, 14'h0000, 1'b1, 16'h4600, 16'h8000, 16'hffe0, 8'h04, 1'b1, 1'b1},
      '{8'h00, 8'h1a, 12'h230, 14'h0021, 1'b0, 16'h4600, 16'h0100, 16'h0100, 8'h00, 1'b1, 1'b1},
      '{8'h00, 8'h1c, 12'h230, 14'h0021, 1'b0, 16'h4600, 16'h0100, 16'h0100, 8'h00, 1'b1, 1'b1},
      '{8'h1b, 8'h18, 12'h2d0, 14'h0021, 1'b0, 16'h5a00, 16'h0100, 16'h0100, 8'h40, 1'b1, 1'b1},
      '{8'h00, 8'h18, 12'h2d0, 14'h0021, 1'b0, 16'h5a00, 16'h0100, 16'h0100, 8'h40, 1'b0, 1'b0},
      '{8'h00, 8'h19, 12'h2d0, 14'h0021, 1'b0, 16'h5a00, 16'h0100, 16'h0100, 8'h40, 1'b0, 1'b1}};
   // pulled-up wires: low only while the block pulls them
   assign criticalAlertIn = criticalAlertOeN ? 1'b1 : criticalAlertOut;
   assign addrSelectIn = overtempAlertOeN ? 1'b1 : overtempAlertOut;
   tra_result_alerts uut (.sys_clk(sys_clk), .rst_n(rst_n), .apbReq(apbReq), .apbRsp(apbRsp),
      .convClkIn(convClkIn), .convIn(convIn), .criticalAlertIn(criticalAlertIn),
      .criticalAlertOut(criticalAlertOut), .criticalAlertOeN(criticalAlertOeN),
      .addrSelectIn(addrSelectIn), .overtempAlertOut(overtempAlertOut),
      .overtempAlertOeN(overtempAlertOeN));
   tra_front_end fe (.run(run), .nextConv(nextConv), .convClkIn(convClkIn), .convIn(convIn));
   // ****************************************************
   // shared tasks
   // ****************************************************
   task automatic wrap_up();
      if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
         fail_count++;
      end
   endtask
   // one apb transfer; waits for pready with a bound, then an idle cycle
   task automatic apb(input logic [7:0] idx, input logic wr, input logic [7:0] wd,
                      output logic [31:0] data);
      int n;
      apbReq <= '{{2'b00, idx, 2'b00}, 1'b1, 1'b0, wr, {24'h0, wd}};
      @(posedge sys_clk);
      apbReq.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (apbRsp.pready !== 1'b1 && n < 20);
      data = apbRsp.prdata;
      chk("pslverr", {31'h0, (idx == 8'h05)}, {31'h0, apbRsp.pslverr});
      if (n >= 20) begin
         fail_count++;
         wrap_up();
      end
      apbReq <= '0;
      @(posedge sys_clk);
   endtask
   // a 16-bit result from its two byte registers
   task automatic rd16(input logic [7:0] hi, input logic [7:0] lo, output logic [15:0] v);
      apb(hi, 1'b0, 8'h00, rd);
      v[15:8] = rd[7:0];
      apb(lo, 1'b0, 8'h00, rd);
      v[7:0] = rd[7:0];
   endtask
   // ****************************************************
   // clock, reset and sequence
   // ****************************************************
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   initial begin
      rst_n = 1'b0;
      run = 1'b0;
      apbReq = '0;
      nextConv = '0;
      fail_count = 0;
      n_checks = 0;
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;
      apb(IDX_DATA, 1'b0, 8'h00, rd);
      chk("window at reset", 32'h0, rd);
      apb(IDX_CFG2, 1'b0, 8'h00, rd);
      chk("cfg2 reset", {24'h0, CFG2_RST}, rd);
      apb(8'h05, 1'b0, 8'h00, rd);
      chk("unmapped data", 32'h0, rd);
      run <= 1'b1;
      foreach (rows[i]) begin
         r = rows[i];
         apb(i[0] ? IDX_CFG1_B : IDX_CFG1_A, 1'b1, r.cfg1, rd);
         apb(IDX_CFG2, 1'b1, r.cfg2, rd);
         nextConv <= '{r.local_limit_flag, r.rem, r.flt};
         repeat (300) @(posedge sys_clk);
         rd16(IDX_LOCAL_MSB, IDX_LOCAL_LSB, w);
         chk("local word", r.eLoc, w);
         rd16(IDX_REM_SIGNED_MSB, IDX_REM_SIGNED_LSB, w);
         chk("remote signed", r.eSgn, w);
         rd16(IDX_REM_UNSIGNED_MSB, IDX_REM_UNSIGNED_LSB, w);
         chk("remote unsigned", r.eUns, w);
         apb(IDX_STATUS1, 1'b0, 8'h00, rd);
         chk("status", r.eSt & (r.flt ? 8'h44 : 8'h5c), rd & (r.flt ? 8'h44 : 8'h5c));
         chk("critical pin", r.eCrit, criticalAlertOeN);
         chk("overtemp pin", r.eOs, overtempAlertOeN);
         chk("pin readback", {29'h0, r.eOs, r.eCrit, r.eOs}, {29'h0, rd[5], rd[1], rd[0]});
         chk("pull values", 32'h0, {30'h0, criticalAlertOut, overtempAlertOut});
      end
      // pointer kept across reads, then cleared by a second reset
      apb(IDX_POINTER, 1'b1, IDX_CFG2, rd);
      repeat (2) begin
         apb(IDX_DATA, 1'b0, 8'h00, rd);
         chk("window kept", 32'h19, rd);
      end
      apb(IDX_DATA, 1'b1, 8'h18, rd);
      apb(IDX_CFG2, 1'b0, 8'h00, rd);
      chk("window write", 32'h18, rd);
      run <= 1'b0;
      repeat (40) @(posedge sys_clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      apb(IDX_DATA, 1'b0, 8'h00, rd);
      chk("window after reset", 32'h0, rd);
      wrap_up();
   end
endmodule // testbench
